// ---- alm_consts.svh ----
// Constants for the eight-bit logic, add, subtract and multiply datapath
`ifndef ALM_CONSTS_SVH
`define ALM_CONSTS_SVH

// Datapath and storage sizes
`define ALM_DW 8
`define ALM_NREG 16
`define ALM_MEM_DEPTH 256
`define ALM_ADDR_W 12

// Register offsets (byte addresses)
`define ALM_OFF_CMD 12'h000
`define ALM_OFF_FLAGS 12'h004
`define ALM_OFF_ACC 12'h008

// Register bank window 0x040..0x07c, data memory window 0x400..0x7fc
`define ALM_BANK_LSB 6
`define ALM_BANK_TAG 6'h01
`define ALM_BANK_IDX_HI 5
`define ALM_MEM_LSB 10
`define ALM_MEM_TAG 2'h1
`define ALM_MEM_IDX_HI 9
`define ALM_WORD_LSB 2
`define ALM_ALIGNED 2'h0

// Reset values
`define ALM_BYTE_ZERO 8'h00
`define ALM_FLAGS_RST 3'h0
`define ALM_CMD_RST 32'h0000_0000

`endif

// ---- alm_pkg.sv ----
// Types shared by the datapath files
package alm_pkg;

  typedef logic [31:0] alm_word_t;
  typedef logic [7:0] alm_byte_t;

  // Operation selector, bits 3:0 of the command word
  typedef enum logic [3:0] {
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_ADD,
    OP_ADD_WITH_CARRY,
    OP_MINUEND_FIRST_DIFFERENCE,
    OP_MINUEND_FIRST_BORROW_DIFFERENCE,
    OP_REVERSED_DIFFERENCE,
    OP_REVERSED_BORROW_DIFFERENCE,
    OP_UNSIGNED_PRODUCT,
    OP_SIGNED_PRODUCT
  } alm_op_t;

  // Operand form, bits 5:4 of the command word
  typedef enum logic [1:0] {
    FORM_THREE_REG,
    FORM_TWO_REG,
    FORM_IMMEDIATE,
    FORM_MEMORY
  } alm_form_t;

  // Command word as written over the bus
  typedef struct packed {
    alm_byte_t imm;
    logic [3:0] src_b;
    logic [3:0] src_a;
    logic [3:0] dst;
    logic [5:0] spare;
    alm_form_t form;
    alm_op_t op;
  } alm_cmd_t;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic z;
    logic v;
    logic c;
  } alm_flags_t;

  // Result bundle of the arithmetic unit
  typedef struct packed {
    alm_byte_t dst;
    alm_byte_t acc;
    alm_flags_t flags;
  } alm_alu_out_t;

  // Address decode outcome
  typedef enum logic [2:0] {
    RGN_NONE,
    RGN_CMD,
    RGN_FLAGS,
    RGN_ACC,
    RGN_BANK,
    RGN_MEM
  } alm_region_t;

endpackage

// ---- alm_alu.sv ----
// Combinational logic, add, subtract and multiply unit
`timescale 1ns/10ps
`include "alm_consts.svh"

module alm_alu (
  input wire alm_pkg::alm_op_t op,
  input wire alm_pkg::alm_byte_t op1,
  input wire alm_pkg::alm_byte_t op2,
  input wire alm_pkg::alm_flags_t flags_in,
  output alm_pkg::alm_alu_out_t res
);

  // Sum of x, y and a carry-in with carry-out and signed overflow
  function automatic logic [`ALM_DW+1:0] add8(input alm_pkg::alm_byte_t x,
                                              input alm_pkg::alm_byte_t y,
                                              input logic ci);
    logic [`ALM_DW:0] s;
    s = {1'b0, x} + {1'b0, y} + {{`ALM_DW{1'b0}}, ci};
    add8 = {s[`ALM_DW], (x[`ALM_DW-1] == y[`ALM_DW-1]) && (s[`ALM_DW-1] != x[`ALM_DW-1]),
            s[`ALM_DW-1:0]};
  endfunction

  logic [`ALM_DW+1:0] arith;
  logic arith_op;
  logic [2*`ALM_DW-1:0] prod;
  logic signed [2*`ALM_DW-1:0] sprod;
  alm_pkg::alm_byte_t logic_val;

  // Subtraction is x + ~y + carry, so carry out means no borrow
  always_comb begin
    arith = '0;
    arith_op = 1'b1;
    unique case (op)
      alm_pkg::OP_ADD: arith = add8(op1, op2, 1'b0);
      alm_pkg::OP_ADD_WITH_CARRY: arith = add8(op1, op2, flags_in.c);
      alm_pkg::OP_MINUEND_FIRST_DIFFERENCE: arith = add8(op1, ~op2, 1'b1);
      alm_pkg::OP_MINUEND_FIRST_BORROW_DIFFERENCE: arith = add8(op1, ~op2, flags_in.c);
      alm_pkg::OP_REVERSED_DIFFERENCE: arith = add8(op2, ~op1, 1'b1);
      alm_pkg::OP_REVERSED_BORROW_DIFFERENCE: arith = add8(op2, ~op1, flags_in.c);
      default: arith_op = 1'b0;
    endcase
  end

  // Products in both signednesses, only one is used
  always_comb begin
    prod = {{`ALM_DW{1'b0}}, op1} * {{`ALM_DW{1'b0}}, op2};
    sprod = $signed({{`ALM_DW{op1[`ALM_DW-1]}}, op1}) * $signed({{`ALM_DW{op2[`ALM_DW-1]}}, op2});
  end

  // Bitwise results
  always_comb begin
    logic_val = op1 & op2;
    if (op == alm_pkg::OP_OR) begin
      logic_val = op1 | op2;
    end else if (op == alm_pkg::OP_XOR) begin
      logic_val = op1 ^ op2;
    end
  end

  // Result steering; flags pass through unless the operation owns them
  always_comb begin
    res.flags = flags_in;
    res.dst = logic_val;
    res.acc = logic_val;
    if (op == alm_pkg::OP_UNSIGNED_PRODUCT) begin
      res.dst = prod[2*`ALM_DW-1:`ALM_DW];
      res.acc = prod[`ALM_DW-1:0];
    end else if (op == alm_pkg::OP_SIGNED_PRODUCT) begin
      res.dst = sprod[2*`ALM_DW-1:`ALM_DW];
      res.acc = sprod[`ALM_DW-1:0];
    end else if (arith_op) begin
      res.dst = arith[`ALM_DW-1:0];
      res.acc = arith[`ALM_DW-1:0];
      res.flags.c = arith[`ALM_DW+1];
      res.flags.v = arith[`ALM_DW];
      res.flags.z = (arith[`ALM_DW-1:0] == `ALM_BYTE_ZERO);
    end else begin
      res.flags.z = (logic_val == `ALM_BYTE_ZERO);
    end
  end

endmodule

// ---- alm_datapath.sv ----
// APB slave holding the register bank, data memory, flags and executing one operation per command-register write
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "alm_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Three-register form: operands from second and third register, result to first.
// - Two-register form: second register first operand, first register second, result first.
// - Immediate form: register is destination and first operand, constant second.
// - Memory form: register is destination and first operand, memory byte second.
// - AND gives bitwise AND; only zero flag and accumulator change.
// - OR gives bitwise OR; only zero flag and accumulator change.
// - XOR gives bitwise XOR; only zero flag and accumulator change.
// - Addition writes eight-bit sum; carry set when sum exceeds eight bits.
// - Add with carry adds incoming carry; carry set on unsigned overflow.
// - First minus second; carry cleared when the subtraction borrows.
// - First minus second minus one plus carry; carry cleared on borrow.
// - Second minus first; carry cleared when a borrow occurs.
// - Second minus first minus one plus carry; carry cleared on borrow.
// - Unsigned product: high byte to destination, low byte to accumulator, flags kept.
// - Signed product split the same way; all flags kept.
module alm_datapath (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ALM_ADDR_W-1:0] paddr,
  input wire alm_pkg::alm_word_t pwdata,
  output alm_pkg::alm_word_t prdata,
  output logic pready,
  output logic pslverr,
  output alm_pkg::alm_byte_t acc,
  output alm_pkg::alm_flags_t flags
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Address region, used for both the read answer and the write effect
  function automatic alm_pkg::alm_region_t region_of(input logic [`ALM_ADDR_W-1:0] addr);
    region_of = alm_pkg::RGN_NONE;
    if (addr == `ALM_OFF_CMD) begin
      region_of = alm_pkg::RGN_CMD;
    end else if (addr == `ALM_OFF_FLAGS) begin
      region_of = alm_pkg::RGN_FLAGS;
    end else if (addr == `ALM_OFF_ACC) begin
      region_of = alm_pkg::RGN_ACC;
    end else if (addr[`ALM_WORD_LSB-1:0] != `ALM_ALIGNED) begin
      region_of = alm_pkg::RGN_NONE;
    end else if (addr[`ALM_ADDR_W-1:`ALM_BANK_LSB] == `ALM_BANK_TAG) begin
      region_of = alm_pkg::RGN_BANK;
    end else if (addr[`ALM_ADDR_W-1:`ALM_MEM_LSB] == `ALM_MEM_TAG) begin
      region_of = alm_pkg::RGN_MEM;
    end
  endfunction

  // Operation codes above the last defined one are refused
  function automatic logic op_legal(input alm_pkg::alm_op_t op);
    unique case (op)
      alm_pkg::OP_AND, alm_pkg::OP_OR, alm_pkg::OP_XOR, alm_pkg::OP_ADD,
      alm_pkg::OP_ADD_WITH_CARRY, alm_pkg::OP_MINUEND_FIRST_DIFFERENCE,
      alm_pkg::OP_MINUEND_FIRST_BORROW_DIFFERENCE, alm_pkg::OP_REVERSED_DIFFERENCE,
      alm_pkg::OP_REVERSED_BORROW_DIFFERENCE, alm_pkg::OP_UNSIGNED_PRODUCT,
      alm_pkg::OP_SIGNED_PRODUCT: op_legal = 1'b1;
      default: op_legal = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  alm_pkg::alm_byte_t bank_q [`ALM_NREG];
  alm_pkg::alm_byte_t dmem_q [`ALM_MEM_DEPTH];
  alm_pkg::alm_byte_t acc_q;
  alm_pkg::alm_flags_t flags_q;
  alm_pkg::alm_cmd_t cmd_q;
  alm_pkg::alm_word_t prdata_q;
  logic pready_q;
  logic pslverr_q;

  alm_pkg::alm_region_t rgn_c;
  alm_pkg::alm_cmd_t cmd_c;
  alm_pkg::alm_byte_t op1_c;
  alm_pkg::alm_byte_t op2_c;
  alm_pkg::alm_alu_out_t alu_c;
  logic [`ALM_BANK_IDX_HI-`ALM_WORD_LSB:0] bank_idx;
  logic [`ALM_MEM_IDX_HI-`ALM_WORD_LSB:0] mem_idx;
  logic take_c;
  logic wr_take;
  logic exec_c;

  assign rgn_c = region_of(paddr);
  assign cmd_c = alm_pkg::alm_cmd_t'(pwdata);
  assign bank_idx = paddr[`ALM_BANK_IDX_HI:`ALM_WORD_LSB];
  assign mem_idx = paddr[`ALM_MEM_IDX_HI:`ALM_WORD_LSB];

  // A write counts only at the edge where the access phase sees pready
  assign take_c = psel && penable && pready_q;
  assign wr_take = take_c && pwrite && !pslverr_q;
  assign exec_c = wr_take && (rgn_c == alm_pkg::RGN_CMD);

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer: one access cycle, data and error caught in the setup cycle

  // Pready rises for the cycle after every setup, so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
    end
  end

  // Read data and error; nothing but bus writes changes state, so early capture is safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= (rgn_c == alm_pkg::RGN_NONE) ||
                   (pwrite && rgn_c == alm_pkg::RGN_CMD && !op_legal(cmd_c.op));
      prdata_q <= '0;
      if (!pwrite) begin
        unique case (rgn_c)
          alm_pkg::RGN_CMD: prdata_q <= cmd_q;
          alm_pkg::RGN_FLAGS: prdata_q <= alm_pkg::alm_word_t'(flags_q);
          alm_pkg::RGN_ACC: prdata_q <= alm_pkg::alm_word_t'(acc_q);
          alm_pkg::RGN_BANK: prdata_q <= alm_pkg::alm_word_t'(bank_q[bank_idx]);
          alm_pkg::RGN_MEM: prdata_q <= alm_pkg::alm_word_t'(dmem_q[mem_idx]);
          alm_pkg::RGN_NONE: prdata_q <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operand selection by form

  always_comb begin
    unique case (cmd_c.form)
      alm_pkg::FORM_THREE_REG: begin
        op1_c = bank_q[cmd_c.src_a];
        op2_c = bank_q[cmd_c.src_b];
      end
      alm_pkg::FORM_TWO_REG: begin
        op1_c = bank_q[cmd_c.src_a];
        op2_c = bank_q[cmd_c.dst];
      end
      alm_pkg::FORM_IMMEDIATE: begin
        op1_c = bank_q[cmd_c.dst];
        op2_c = cmd_c.imm;
      end
      alm_pkg::FORM_MEMORY: begin
        op1_c = bank_q[cmd_c.dst];
        op2_c = dmem_q[cmd_c.imm];
      end
    endcase
  end

  alm_alu u_alu (
    .op(cmd_c.op),
    .op1(op1_c),
    .op2(op2_c),
    .flags_in(flags_q),
    .res(alu_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register updates

  // result to the first named register; a bus write loses to execution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `ALM_NREG; i++) begin
        bank_q[i] <= `ALM_BYTE_ZERO;
      end
    end else if (exec_c) begin
      bank_q[cmd_c.dst] <= alu_c.dst;
    end else if (wr_take && rgn_c == alm_pkg::RGN_BANK) begin
      bank_q[bank_idx] <= pwdata[`ALM_DW-1:0];
    end
  end

  // Data memory has no reset; software loads it before use
  always_ff @(posedge pclk) begin
    if (wr_take && rgn_c == alm_pkg::RGN_MEM) begin
      dmem_q[mem_idx] <= pwdata[`ALM_DW-1:0];
    end
  end

  // accumulator takes the result or the product low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= `ALM_BYTE_ZERO;
    end else if (exec_c) begin
      acc_q <= alu_c.acc;
    end else if (wr_take && rgn_c == alm_pkg::RGN_ACC) begin
      acc_q <= pwdata[`ALM_DW-1:0];
    end
  end

  // flags follow the unit, which passes kept flags through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `ALM_FLAGS_RST;
    end else if (exec_c) begin
      flags_q <= alu_c.flags;
    end else if (wr_take && rgn_c == alm_pkg::RGN_FLAGS) begin
      flags_q <= alm_pkg::alm_flags_t'(pwdata[$bits(alm_pkg::alm_flags_t)-1:0]);
    end
  end

  // Last executed command for readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= `ALM_CMD_RST;
    end else if (exec_c) begin
      cmd_q <= cmd_c;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign acc = acc_q;
  assign flags = flags_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [`ALM_DW:0] chk_sum;
  logic [`ALM_DW:0] chk_need_d;
  logic [`ALM_DW:0] chk_need_r;
  logic [2*`ALM_DW-1:0] chk_uprod;
  logic signed [2*`ALM_DW-1:0] chk_sprod;
  logic chk_prod_op;

  // Reference figures computed independently of the unit
  always_comb begin
    chk_sum = {1'b0, op1_c} + {1'b0, op2_c} +
              {{`ALM_DW{1'b0}}, (cmd_c.op == alm_pkg::OP_ADD_WITH_CARRY) && flags_q.c};
    chk_need_d = {1'b0, op2_c} + {{`ALM_DW{1'b0}}, !flags_q.c};
    chk_need_r = {1'b0, op1_c} + {{`ALM_DW{1'b0}}, !flags_q.c};
    chk_uprod = {{`ALM_DW{1'b0}}, op1_c} * {{`ALM_DW{1'b0}}, op2_c};
    chk_sprod = $signed(op1_c) * $signed(op2_c);
    chk_prod_op = (cmd_c.op == alm_pkg::OP_UNSIGNED_PRODUCT) ||
                  (cmd_c.op == alm_pkg::OP_SIGNED_PRODUCT);
  end

  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_three_form_or: assert property (
    exec_c && cmd_c.form == alm_pkg::FORM_THREE_REG && cmd_c.op == alm_pkg::OP_OR |=>
    bank_q[$past(cmd_c.dst)] == ($past(bank_q[cmd_c.src_a]) | $past(bank_q[cmd_c.src_b])))
    else $error("Three-register OR wrote a wrong result");

  a_two_form_xor: assert property (
    exec_c && cmd_c.form == alm_pkg::FORM_TWO_REG && cmd_c.op == alm_pkg::OP_XOR |=>
    bank_q[$past(cmd_c.dst)] == ($past(bank_q[cmd_c.src_a]) ^ $past(bank_q[cmd_c.dst])))
    else $error("Two-register XOR wrote a wrong result");

  a_imm_form_and: assert property (
    exec_c && cmd_c.form == alm_pkg::FORM_IMMEDIATE && cmd_c.op == alm_pkg::OP_AND |=>
    bank_q[$past(cmd_c.dst)] == ($past(bank_q[cmd_c.dst]) & $past(cmd_c.imm)))
    else $error("Immediate AND wrote a wrong result");

  a_mem_form_add: assert property (
    exec_c && cmd_c.form == alm_pkg::FORM_MEMORY && cmd_c.op == alm_pkg::OP_ADD |=>
    acc_q == $past(bank_q[cmd_c.dst]) + $past(dmem_q[cmd_c.imm]))
    else $error("Memory-form add used a wrong operand");

  a_and_keeps_cv: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_AND |=>
    acc_q == ($past(op1_c) & $past(op2_c)) && flags_q.c == $past(flags_q.c) &&
    flags_q.v == $past(flags_q.v))
    else $error("AND result or kept flags wrong");

  a_or_keeps_cv: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_OR |=>
    acc_q == ($past(op1_c) | $past(op2_c)) && $stable(flags_q.c) && $stable(flags_q.v))
    else $error("OR result or kept flags wrong");

  a_xor_keeps_cv: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_XOR |=>
    acc_q == ($past(op1_c) ^ $past(op2_c)) && $stable(flags_q.c) && $stable(flags_q.v))
    else $error("XOR result or kept flags wrong");

  a_add_carry: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_ADD |=>
    acc_q == $past(chk_sum[`ALM_DW-1:0]) && flags_q.c == $past(chk_sum[`ALM_DW]))
    else $error("Addition sum or carry wrong");

  a_add_with_carry_carry: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_ADD_WITH_CARRY |=>
    acc_q == $past(chk_sum[`ALM_DW-1:0]) && flags_q.c == $past(chk_sum[`ALM_DW]))
    else $error("Add with carry sum or carry wrong");

  a_minuend_first_difference_borrow: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_MINUEND_FIRST_DIFFERENCE |=>
    acc_q == $past(op1_c) - $past(op2_c) && flags_q.c == ($past(op1_c) >= $past(op2_c)))
    else $error("First-minus-second difference or carry wrong");

  a_minuend_first_borrow_difference_borrow: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_MINUEND_FIRST_BORROW_DIFFERENCE |=>
    flags_q.c == ({1'b0, $past(op1_c)} >= $past(chk_need_d)) &&
    acc_q == $past(op1_c) - $past(chk_need_d[`ALM_DW-1:0]))
    else $error("First-minus-second with borrow wrong");

  a_reversed_difference_borrow: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_REVERSED_DIFFERENCE |=>
    acc_q == $past(op2_c) - $past(op1_c) && flags_q.c == ($past(op2_c) >= $past(op1_c)))
    else $error("Reversed difference or carry wrong");

  a_reversed_borrow_difference_borrow: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_REVERSED_BORROW_DIFFERENCE |=>
    flags_q.c == ({1'b0, $past(op2_c)} >= $past(chk_need_r)) &&
    acc_q == $past(op2_c) - $past(chk_need_r[`ALM_DW-1:0]))
    else $error("Reversed difference with borrow wrong");

  a_unsigned_split: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_UNSIGNED_PRODUCT |=>
    bank_q[$past(cmd_c.dst)] == $past(chk_uprod[2*`ALM_DW-1:`ALM_DW]) &&
    acc_q == $past(chk_uprod[`ALM_DW-1:0]) && $stable(flags_q))
    else $error("Unsigned product split or flags wrong");

  a_signed_split: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_SIGNED_PRODUCT |=>
    bank_q[$past(cmd_c.dst)] == $past(chk_sprod[2*`ALM_DW-1:`ALM_DW]) &&
    acc_q == $past(chk_sprod[`ALM_DW-1:0]) && $stable(flags_q))
    else $error("Signed product split or flags wrong");

  a_zero_tracks: assert property (
    exec_c && !chk_prod_op |=>
    flags_q.z == (acc_q == `ALM_BYTE_ZERO) && acc_q == bank_q[$past(cmd_c.dst)])
    else $error("Zero flag or accumulator copy wrong");

  a_add_overflow: assert property (
    exec_c && cmd_c.op == alm_pkg::OP_ADD |=>
    flags_q.v == ($past(op1_c[`ALM_DW-1]) == $past(op2_c[`ALM_DW-1]) &&
                  acc_q[`ALM_DW-1] != $past(op1_c[`ALM_DW-1])))
    else $error("Addition overflow flag wrong");

  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("Bus answer not a single access cycle");

  c_memory_exec: cover property (exec_c && cmd_c.form == alm_pkg::FORM_MEMORY);
  c_signed_product: cover property (exec_c && cmd_c.op == alm_pkg::OP_SIGNED_PRODUCT);
  c_borrow_clear: cover property (exec_c ##1 !flags_q.c);
  c_illegal_op: cover property (take_c && pslverr_q && pwrite);

endmodule

// ---- alm_apb_master.sv ----
// APB master model standing in for the core side of the datapath
`timescale 1ns/10ps
`include "alm_consts.svh"
module alm_apb_master (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [`ALM_ADDR_W-1:0] paddr,
  output alm_pkg::alm_word_t pwdata,
  input wire alm_pkg::alm_word_t prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer; an idle edge first so no signal is driven twice per step
  task automatic xfer(input logic w, input logic [11:0] a, input alm_pkg::alm_word_t d,
                      output alm_pkg::alm_word_t q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer however long it takes; only the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data shows the inverse, never the stale value
    pwdata <= ~d;
  endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the logic, add, subtract and multiply datapath
`timescale 1ns/10ps
`include "alm_consts.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [`ALM_ADDR_W-1:0] paddr;
  alm_pkg::alm_word_t pwdata, prdata, q;
  alm_pkg::alm_byte_t acc;
  alm_pkg::alm_flags_t flags;
  logic [18:0] x;
  logic [2:0] f;
  logic [7:0] va [4] = '{8'h00, 8'ha5, 8'h80, 8'h7f};
  logic [7:0] vb [4] = '{8'h00, 8'h5a, 8'h80, 8'h01};
  int miscompares = 0;
  int tests_run = 0;

  always #10 pclk = ~pclk;

  alm_datapath uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc(acc), .flags(flags));
  alm_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and bus helpers
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    m.xfer(1'b1, a, d, q, e);
    chk("pslverr", 32'(ee), 32'(e));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string n);
    m.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(n, ex, q);
  endtask
  function automatic logic [31:0] cmd(input logic [3:0] op, input logic [1:0] fm,
      input logic [3:0] d, input logic [3:0] sa, input logic [3:0] sb, input logic [7:0] im);
    return {im, sb, sa, d, 6'h00, fm, op};
  endfunction

  // Reference result {dst, acc, flags z v c}; subtract is minuend plus inverted subtrahend plus carry in
  function automatic logic [18:0] ref_op(input logic [3:0] op, input logic [7:0] x,
      input logic [7:0] y, input logic [2:0] f);
    logic [7:0] a, b, r;
    logic [8:0] s;
    logic [15:0] p;
    logic ci;
    a = (op == 4'h7 || op == 4'h8) ? y : x;
    b = (op == 4'h3 || op == 4'h4) ? y : (op == 4'h5 || op == 4'h6) ? ~y : ~x;
    ci = (op == 4'h3) ? 1'b0 : (op == 4'h5 || op == 4'h7) ? 1'b1 : f[0];
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    r = s[7:0];
    // Signed product as the low 16 bits of a product of sign-extended operands
    p = (op == 4'ha) ? ({{8{x[7]}}, x} * {{8{y[7]}}, y}) : ({8'h00, x} * {8'h00, y});
    case (op)
      4'h0: return {x & y, x & y, (x & y) == 8'h00, f[1:0]};
      4'h1: return {x | y, x | y, (x | y) == 8'h00, f[1:0]};
      4'h2: return {x ^ y, x ^ y, (x ^ y) == 8'h00, f[1:0]};
      4'h9, 4'ha: return {p, f};
      default: return {r, r, r == 8'h00, (a[7] == b[7]) && (r[7] != a[7]), s[8]};
    endcase
  endfunction

  // Verdict and end of run
  task results;
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ALM_OFF_ACC, 32'h0000_0000, "acc reset");
    rd(`ALM_OFF_FLAGS, 32'h0000_0000, "flags reset");
    // Every op over boundary operands, carry and overflow preset on odd pairs
    for (int op = 0; op < 11; op++) begin
      for (int i = 0; i < 4; i++) begin
        f = i[0] ? 3'h3 : 3'h0;
        wr(`ALM_OFF_FLAGS, {29'h0, f}, 1'b0);
        wr(12'h048, {24'h0, va[i]}, 1'b0);
        wr(12'h04c, {24'h0, vb[i]}, 1'b0);
        wr(`ALM_OFF_CMD, cmd(op[3:0], 2'h0, 4'h1, 4'h2, 4'h3, 8'h00), 1'b0);
        x = ref_op(op[3:0], va[i], vb[i], f);
        rd(12'h044, {24'h0, x[18:11]}, "dst");
        chk("acc", {24'h0, x[10:3]}, {24'h0, acc});
        chk("flags", {29'h0, x[2:0]}, {29'h0, flags});
      end
    end
    // Operand order of the two-register, immediate and memory forms
    wr(12'h050, 32'h0000_0010, 1'b0);
    wr(12'h054, 32'h0000_0003, 1'b0);
    wr(`ALM_OFF_CMD, cmd(4'h5, 2'h1, 4'h4, 4'h5, 4'h0, 8'h00), 1'b0);
    rd(12'h050, 32'h0000_00f3, "two reg");
    wr(`ALM_OFF_CMD, cmd(4'h7, 2'h2, 4'h4, 4'h0, 4'h0, 8'h05), 1'b0);
    rd(12'h050, 32'h0000_0012, "immediate");
    wr(12'h480, 32'h0000_0040, 1'b0);
    wr(`ALM_OFF_CMD, cmd(4'h5, 2'h3, 4'h4, 4'h0, 4'h0, 8'h20), 1'b0);
    rd(12'h050, 32'h0000_00d2, "memory");
    // Illegal op is refused and leaves the destination alone
    wr(`ALM_OFF_CMD, cmd(4'hb, 2'h2, 4'h4, 4'h0, 4'h0, 8'h01), 1'b1);
    rd(12'h050, 32'h0000_00d2, "refused op");
    // Bitwise and add ops in the two-register, immediate and memory forms
    wr(`ALM_OFF_CMD, cmd(4'h2, 2'h1, 4'h4, 4'h5, 4'h0, 8'h00), 1'b0);
    rd(12'h050, 32'h0000_00d1, "two reg xor");
    wr(`ALM_OFF_CMD, cmd(4'h0, 2'h2, 4'h4, 4'h0, 4'h0, 8'h0f), 1'b0);
    rd(12'h050, 32'h0000_0001, "immediate and");
    wr(`ALM_OFF_CMD, cmd(4'h3, 2'h3, 4'h4, 4'h0, 4'h0, 8'h20), 1'b0);
    rd(12'h050, 32'h0000_0041, "memory add");
    rd(12'h00c, 32'h0000_0000, "unmapped");
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    results();
  end
endmodule
